// ==== osd_cfg.svh ====
// Purpose: constants for the original size detector
// Assumes: 250 MHz clock, 5-bit detector pattern {center, rear, beam1, beam2, beam3}
// Notes: pattern value of a table row n is 32 - n
`ifndef OSD_CFG_SVH
`define OSD_CFG_SVH

`define OSD_PAT_W 5
`define OSD_PAT_NONE 5'h1F
`define OSD_PAT_HALF_LE 5'h1E
`define OSD_PAT_HALF_ROT 5'h17
`define OSD_PAT_LET_ROT 5'h16
`define OSD_PAT_LET_LE 5'h10
`define OSD_PAT_LEGAL 5'h06
`define OSD_PAT_LEDGER 5'h00
`define OSD_CLK_MHZ 250
`define OSD_MOD_HALF_NS 2000
`define OSD_MOD_HALF_CYC ((`OSD_MOD_HALF_NS * `OSD_CLK_MHZ) / 1000)
`define OSD_MOD_CNT_W 10
`define OSD_CNT_ZERO 10'h000
`define OSD_CNT_ONE 10'h001

`endif

// ==== osd_pkg.sv ====
// Purpose: types for the original size detector
// Assumes: nothing beyond the config header
// Notes: size codes are what the panel and ratio logic see
package osd_pkg;
  typedef enum logic [2:0] {
    OSD_NO_ORIGINAL = 3'h0,
    OSD_HALF_LETTER_LONG_EDGE = 3'h1,
    OSD_HALF_LETTER_ROTATED = 3'h2,
    OSD_LETTER_ROTATED = 3'h3,
    OSD_LETTER_LONG_EDGE_FEED = 3'h4,
    OSD_LEGAL_SHEET = 3'h5,
    OSD_LEDGER_SHEET = 3'h6
  } osd_size_t;
endpackage : osd_pkg

// ==== osd_emitter.sv ====
// Purpose: pulse modulation of the detector LEDs and sampling slot
// Assumes: detector inputs settle within one half period
// Notes: sample strobe falls at the end of each lit half period
`timescale 1ns/1ns
`default_nettype none
`include "osd_cfg.svh"
module osd_emitter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Enable
  input wire logic i_run,
  // Drive and strobes
  output logic o_led_on,
  output logic o_lit_end,
  output logic o_dark_end
);
  localparam logic [`OSD_MOD_CNT_W-1:0] HALF_CNT = `OSD_MOD_CNT_W'(`OSD_MOD_HALF_CYC - 1);
  logic [`OSD_MOD_CNT_W-1:0] cnt_reg;
  logic led_reg;
  wire half_done = (cnt_reg == HALF_CNT);
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !i_run) begin
      cnt_reg <= `OSD_CNT_ZERO;
      led_reg <= 1'b0;
    end else begin
      cnt_reg <= half_done ? `OSD_CNT_ZERO : cnt_reg + `OSD_CNT_ONE;
      if (half_done) begin
        led_reg <= ~led_reg;
      end
    end
  end
  assign o_led_on = led_reg;
  assign o_lit_end = i_run && half_done && led_reg;
  assign o_dark_end = i_run && half_done && !led_reg;
endmodule : osd_emitter
`default_nettype wire

// ==== osd_decode.sv ====
// Purpose: pattern to size decode
// Assumes: pattern bit 1 means absent at that point
// Notes: combinational, o_valid low and no original for unlisted patterns
`timescale 1ns/1ns
`default_nettype none
`include "osd_cfg.svh"
module osd_decode (
  // Pattern
  input wire logic [`OSD_PAT_W-1:0] i_pattern,
  // Result
  output osd_pkg::osd_size_t o_size,
  output logic o_valid
);
  import osd_pkg::*;
  always_comb begin
    o_valid = 1'b1;
    o_size = OSD_NO_ORIGINAL;
    unique case (i_pattern)
      `OSD_PAT_NONE: o_size = OSD_NO_ORIGINAL;
      `OSD_PAT_HALF_LE: o_size = OSD_HALF_LETTER_LONG_EDGE;
      `OSD_PAT_HALF_ROT: o_size = OSD_HALF_LETTER_ROTATED;
      `OSD_PAT_LET_ROT: o_size = OSD_LETTER_ROTATED;
      `OSD_PAT_LET_LE: o_size = OSD_LETTER_LONG_EDGE_FEED;
      `OSD_PAT_LEGAL: o_size = OSD_LEGAL_SHEET;
      `OSD_PAT_LEDGER: o_size = OSD_LEDGER_SHEET;
      default: o_valid = 1'b0;
    endcase
  end
endmodule : osd_decode
`default_nettype wire

// ==== osd_top.sv ====
// Purpose: original size detector for the platen glass
// Assumes: inputs synchronous to i_clk; detector output high means no original
// Notes: result held while the platen sensor is on or the pattern is unlisted
// Summary of operation
// - Detector high means absent, low present
// - All absent gives no original, no selection
// - Row 2 decodes half letter long edge
// - Row 9 decodes half letter rotated
// - Row 10 decodes letter rotated
// - Size decision shown and selection triggered
// - Unlisted patterns keep last result
// - Platen off: evaluate continuously, update changes
// - Size change never moves the carriage
// - Platen on: freeze previous result
// - Pulse modulated emission, judge modulated reflection
// - Detect only with carriage at home
`timescale 1ns/1ns
`default_nettype none
`include "osd_cfg.svh"
module osd_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Detectors, high while receiver sees no reflection
  input wire logic i_center_detector,
  input wire logic i_rear_detector,
  input wire logic i_beam_detector_one,
  input wire logic i_beam_detector_two,
  input wire logic i_beam_detector_three,
  // Machine state
  input wire logic i_platen_on,
  input wire logic i_carriage_home,
  // Emitter drive
  output logic o_led_on,
  // Result
  output osd_pkg::osd_size_t o_size,
  output logic o_no_original,
  output logic o_select_paper,
  output logic o_size_update,
  output logic o_carriage_move
);
  import osd_pkg::*;

  logic [`OSD_PAT_W-1:0] raw_now;
  logic [`OSD_PAT_W-1:0] dark_reg;
  logic [`OSD_PAT_W-1:0] pat_reg;
  logic pat_ok_reg;
  logic lit_end;
  logic dark_end;
  logic run;
  osd_size_t dec_size;
  logic dec_valid;
  osd_size_t size_reg;
  osd_size_t size_next;
  logic upd_reg;
  logic upd_next;
  logic [`OSD_PAT_W-1:0] present_dark;
  logic [`OSD_PAT_W-1:0] present_lit;
  logic [`OSD_PAT_W-1:0] point_absent;

  assign run = i_carriage_home;

  osd_emitter u_emit (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_run(run),
    .o_led_on(o_led_on),
    .o_lit_end(lit_end),
    .o_dark_end(dark_end)
  );

  assign raw_now = {i_center_detector, i_rear_detector, i_beam_detector_one,
                    i_beam_detector_two, i_beam_detector_three};

  // present needs modulation: low when lit, high when dark
  assign present_dark = dark_reg;
  assign present_lit = ~raw_now;

  for (genvar gi = 0; gi < `OSD_PAT_W; gi++) begin : g_point
    assign point_absent[gi] = !(present_dark[gi] && present_lit[gi]);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      dark_reg <= `OSD_PAT_NONE;
      pat_reg <= `OSD_PAT_NONE;
      pat_ok_reg <= 1'b0;
    end else begin
      if (dark_end) begin
        dark_reg <= raw_now;
      end
      pat_ok_reg <= lit_end;
      if (lit_end) begin
        pat_reg <= point_absent;
      end
    end
  end

  osd_decode u_dec (
    .i_pattern(pat_reg),
    .o_size(dec_size),
    .o_valid(dec_valid)
  );

  always_comb begin
    size_next = size_reg;
    upd_next = 1'b0;
    if (pat_ok_reg && !i_platen_on && run && dec_valid) begin
      size_next = dec_size;
      upd_next = (dec_size != size_reg);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      size_reg <= OSD_NO_ORIGINAL;
      upd_reg <= 1'b0;
    end else begin
      size_reg <= size_next;
      upd_reg <= upd_next;
    end
  end

  assign o_size = size_reg;
  assign o_size_update = upd_reg;
  assign o_no_original = (size_reg == OSD_NO_ORIGINAL);
  assign o_select_paper = upd_reg && (size_reg != OSD_NO_ORIGINAL);
  assign o_carriage_move = 1'b0;

  // Assertions
  // freeze check
  frozen_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_platen_on |=> $stable(size_reg)) else $error("size changed while platen on");
  hold_unlisted_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !dec_valid |=> $stable(size_reg)) else $error("unlisted pattern changed size");
  take_decision_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_ok_reg && !i_platen_on && run && dec_valid |=> size_reg == $past(dec_size))
    else $error("valid decision not taken");
  select_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_select_paper |-> $past(pat_ok_reg) && !o_no_original) else $error("bad select");
  none_noselect_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_no_original |-> !o_select_paper) else $error("selection with no original");
  carriage_idle_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_size_update |-> !o_carriage_move) else $error("carriage moved");
  home_only_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !run |=> !o_led_on) else $error("emitter on away from home");
  ledger_dec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_reg == `OSD_PAT_LEDGER |-> dec_valid && dec_size == OSD_LEDGER_SHEET)
    else $error("ledger decode wrong");
  half_dec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_reg == `OSD_PAT_HALF_LE |-> dec_size == OSD_HALF_LETTER_LONG_EDGE)
    else $error("half letter decode wrong");
  reset_none_a: assert property (@(posedge i_clk)
    !i_nrst |=> o_no_original) else $error("reset not no original");

  reset_dark_a: assert property (@(posedge i_clk)
    !i_nrst |=> !o_led_on && !o_size_update) else $error("activity during reset");

  // Steps of one detection pass
  sequence lit_sample_s;
    lit_end && run;
  endsequence
  sequence new_size_s;
    pat_ok_reg && run && !i_platen_on && dec_valid && (dec_size != size_reg);
  endsequence
  sequence frozen_sample_s;
    pat_ok_reg && i_platen_on;
  endsequence
  sequence unlisted_s;
    pat_ok_reg && !dec_valid;
  endsequence
  sequence same_size_s;
    pat_ok_reg && dec_valid && (dec_size == size_reg);
  endsequence

  size_walk_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_sample_s ##1 new_size_s |=> o_size_update && (o_size == $past(dec_size)))
    else $error("new size not shown");

  platen_walk_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_sample_s ##1 frozen_sample_s |=> !o_size_update && $stable(o_size))
    else $error("size moved under platen");

  unlisted_walk_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_sample_s ##1 unlisted_s |=> !o_size_update && $stable(o_size))
    else $error("unlisted pass moved size");

  same_size_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_sample_s ##1 same_size_s |=> !o_size_update && $stable(o_size))
    else $error("repeat decision flagged");

  dark_capture_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dark_end |=> dark_reg == $past(raw_now)) else $error("dark sample lost");

  dark_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !dark_end |=> $stable(dark_reg)) else $error("dark sample moved");

  lit_capture_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_end && (dark_reg == `OSD_PAT_NONE) |=> pat_reg == $past(raw_now))
    else $error("lit sample lost");

  stray_light_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_end && !(|dark_reg) |=> pat_reg == `OSD_PAT_NONE)
    else $error("stray light taken as original");

  pattern_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !lit_end |=> $stable(pat_reg)) else $error("pattern moved off strobe");

  lit_phase_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_end |-> o_led_on ##1 !o_led_on) else $error("lit strobe out of phase");

  dark_phase_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dark_end |-> !o_led_on ##1 o_led_on) else $error("dark strobe out of phase");

  sample_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_end |=> pat_ok_reg) else $error("sample not flagged");

  flag_source_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_ok_reg |-> $past(lit_end)) else $error("flag without sample");

  present_point_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_end && (dark_reg == `OSD_PAT_NONE) && !(|raw_now) |=> pat_reg == `OSD_PAT_LEDGER)
    else $error("low points not present");

  absent_point_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_end && (raw_now == `OSD_PAT_NONE) |=> pat_reg == `OSD_PAT_NONE)
    else $error("high points not absent");

  bit_order_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lit_end && (dark_reg == `OSD_PAT_NONE) |=> pat_reg[`OSD_PAT_W-1] == $past(i_center_detector)
    && pat_reg[0] == $past(i_beam_detector_three))
    else $error("pattern bit order wrong");

  select_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_size_update && !o_no_original |-> o_select_paper)
    else $error("size decision without select");

  update_change_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_size_update |-> $changed(o_size)) else $error("update without change");

  change_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $changed(o_size) && $past(i_nrst) |-> o_size_update)
    else $error("change without update");

  one_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_size_update |=> !o_size_update) else $error("update pulse too long");

  away_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !run |=> $stable(size_reg)) else $error("size moved away from home");

  away_quiet_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !run |-> !lit_end && !dark_end) else $error("strobe away from home");

  none_dec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_reg == `OSD_PAT_NONE |-> dec_valid && dec_size == OSD_NO_ORIGINAL)
    else $error("no original decode wrong");

  half_rot_dec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_reg == `OSD_PAT_HALF_ROT |-> dec_valid && dec_size == OSD_HALF_LETTER_ROTATED)
    else $error("half rotated decode wrong");

  let_rot_dec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_reg == `OSD_PAT_LET_ROT |-> dec_valid && dec_size == OSD_LETTER_ROTATED)
    else $error("letter rotated decode wrong");

  letter_dec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_reg == `OSD_PAT_LET_LE |-> dec_valid && dec_size == OSD_LETTER_LONG_EDGE_FEED)
    else $error("letter decode wrong");

  legal_dec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pat_reg == `OSD_PAT_LEGAL |-> dec_valid && dec_size == OSD_LEGAL_SHEET)
    else $error("legal decode wrong");

  carriage_standby_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $changed(o_size) |-> !o_carriage_move) else $error("carriage moved on change");
endmodule : osd_top
`default_nettype wire

// ==== osd_sensor_model.sv ====
// Purpose: photosensor row facing the size detector
// Assumes: receiver answers within the same cycle
// Notes: reflected light pulls a receiver low only while lit
`timescale 1ns/1ns
`default_nettype none
module osd_sensor_model (
  // Emitter
  input wire logic i_led_on,
  // Originals, 0 where paper lies
  input wire logic [4:0] i_original_n,
  // Stray light, 0 where a receiver is swamped
  input wire logic [4:0] i_ambient_n,
  // Receivers
  output logic [4:0] o_detect
);
  assign o_detect = (i_led_on ? i_original_n : 5'h1F) & i_ambient_n;
endmodule : osd_sensor_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for the size detector
// Assumes: one result per 1000-cycle emitter period
// Notes: each step waits 2200 cycles, over two periods
`timescale 1ns/1ns
`default_nettype none
`include "osd_cfg.svh"
module tb_top;
  import osd_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [4:0] pat = 5'h1F;
  logic [4:0] amb = 5'h1F;
  logic platen = 1'b0;
  logic home = 1'b1;
  logic [4:0] det;
  logic led, no_orig, sel, upd, move;
  osd_size_t size;
  logic [15:0] n_upd = 16'h0000;
  logic [15:0] n_sel = 16'h0000;
  logic [15:0] n_led = 16'h0000;
  logic [15:0] n_move = 16'h0000;
  int num_errors = 0;
  int tests_run = 0;
  always #2 i_clk = ~i_clk;
  osd_sensor_model osd_sensor_model_inst (.i_led_on(led), .i_original_n(pat),
    .i_ambient_n(amb), .o_detect(det));
  osd_top osd_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_center_detector(det[4]),
    .i_rear_detector(det[3]), .i_beam_detector_one(det[2]), .i_beam_detector_two(det[1]),
    .i_beam_detector_three(det[0]), .i_platen_on(platen), .i_carriage_home(home),
    .o_led_on(led), .o_size(size), .o_no_original(no_orig), .o_select_paper(sel),
    .o_size_update(upd), .o_carriage_move(move));
  always @(posedge i_clk) begin
    n_upd <= n_upd + 16'(upd);
    n_sel <= n_sel + 16'(sel);
    n_led <= n_led + 16'(led);
    n_move <= n_move + 16'(move);
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic run(input logic [4:0] p, input logic pl, input logic hm, input osd_size_t es,
    input logic [7:0] eu);
    logic [15:0] u0, s0, l0, m0;
    @(negedge i_clk);
    pat = p;
    platen = pl;
    home = hm;
    @(negedge i_clk);
    u0 = n_upd;
    s0 = n_sel;
    l0 = n_led;
    m0 = n_move;
    repeat (2199) @(negedge i_clk);
    check("size", 8'(size), 8'(es));
    check("no original", 8'(no_orig), 8'(es == OSD_NO_ORIGINAL));
    check("updates", 8'(n_upd - u0), eu);
    check("selects", 8'(n_sel - s0), (es == OSD_NO_ORIGINAL) ? 8'h00 : eu);
    check("carriage", 8'(n_move - m0), 8'h00);
    check("emitter", 8'(n_led != l0), 8'(hm));
  endtask : run
  task automatic t_reset;
    check("reset size", 8'(size), 8'(OSD_NO_ORIGINAL));
    check("reset none", 8'(no_orig), 8'h01);
    $display("test reset done");
  endtask : t_reset
  task automatic t_decode;
    logic [4:0] p[7] = '{`OSD_PAT_HALF_LE, `OSD_PAT_HALF_ROT, `OSD_PAT_LET_ROT,
      `OSD_PAT_LET_LE, `OSD_PAT_LEGAL, `OSD_PAT_LEDGER, `OSD_PAT_NONE};
    osd_size_t s[7] = '{OSD_HALF_LETTER_LONG_EDGE, OSD_HALF_LETTER_ROTATED,
      OSD_LETTER_ROTATED, OSD_LETTER_LONG_EDGE_FEED, OSD_LEGAL_SHEET, OSD_LEDGER_SHEET,
      OSD_NO_ORIGINAL};
    for (int i = 0; i < 7; i++) begin
      run(p[i], 1'b0, 1'b1, s[i], 8'h01);
    end
    $display("test decode done");
  endtask : t_decode
  task automatic t_hold;
    run(`OSD_PAT_LEGAL, 1'b0, 1'b1, OSD_LEGAL_SHEET, 8'h01);
    run(5'h1D, 1'b0, 1'b1, OSD_LEGAL_SHEET, 8'h00);
    run(5'h1A, 1'b0, 1'b1, OSD_LEGAL_SHEET, 8'h00);
    $display("test hold done");
  endtask : t_hold
  task automatic t_platen;
    run(`OSD_PAT_LEDGER, 1'b1, 1'b1, OSD_LEGAL_SHEET, 8'h00);
    run(`OSD_PAT_LEDGER, 1'b0, 1'b1, OSD_LEDGER_SHEET, 8'h01);
    $display("test platen done");
  endtask : t_platen
  task automatic t_home;
    run(`OSD_PAT_LET_LE, 1'b0, 1'b0, OSD_LEDGER_SHEET, 8'h00);
    run(`OSD_PAT_LET_LE, 1'b0, 1'b1, OSD_LETTER_LONG_EDGE_FEED, 8'h01);
    run(`OSD_PAT_LET_LE, 1'b0, 1'b1, OSD_LETTER_LONG_EDGE_FEED, 8'h00);
    $display("test home done");
  endtask : t_home
  task automatic t_ambient;
    run(`OSD_PAT_LET_LE, 1'b0, 1'b0, OSD_LETTER_LONG_EDGE_FEED, 8'h00);
    amb = 5'h00;
    run(`OSD_PAT_LET_LE, 1'b0, 1'b1, OSD_NO_ORIGINAL, 8'h01);
    run(`OSD_PAT_HALF_ROT, 1'b0, 1'b0, OSD_NO_ORIGINAL, 8'h00);
    amb = 5'h1E;
    run(`OSD_PAT_HALF_ROT, 1'b0, 1'b1, OSD_HALF_LETTER_ROTATED, 8'h01);
    $display("test ambient done");
  endtask : t_ambient
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_decode();
    t_hold();
    t_platen();
    t_home();
    t_ambient();
    final_report();
  end
  // Watchdog over the whole planned run
  initial begin
    #250000;
    num_errors++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
